/* File: logic/iad_decoder.sv */
// Indirect address decoder between core datapath, data RAM and program flash
`timescale 1ns/1ps
`default_nettype none

module iad_decoder
    import iad_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic                    req_valid,
    output logic                         req_ready,
    input  wire logic                    req_write,
    input  wire logic                    req_sel,
    input  wire logic [IAD_DATA_W-1:0]   req_wdata,
    input  wire logic [7:0]              pointer_high_byte0,
    input  wire logic [7:0]              pointer_low_byte0,
    input  wire logic [7:0]              pointer_high_byte1,
    input  wire logic [7:0]              pointer_low_byte1,
    output logic                         rsp_valid,
    output logic [IAD_DATA_W-1:0]        rsp_rdata,
    output logic [IAD_RAM_AW-1:0]        ram_addr,
    output logic                         ram_re,
    output logic                         ram_we,
    output logic [IAD_DATA_W-1:0]        ram_wdata,
    input  wire logic [IAD_DATA_W-1:0]   ram_rdata,
    output logic [IAD_FLASH_AW-1:0]      flash_addr,
    output logic                         flash_re,
    input  wire logic [IAD_FLASH_DW-1:0] flash_rdata
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        iad_state_t              st;
        logic [IAD_RAM_AW-1:0]   ram_addr;
        logic                    ram_re;
        logic                    ram_we;
        logic [IAD_DATA_W-1:0]   ram_wdata;
        logic [IAD_FLASH_AW-1:0] flash_addr;
        logic                    flash_re;
        logic                    to_flash;
        logic                    to_null;
        logic                    is_write;
        logic                    rsp_valid;
        logic [IAD_DATA_W-1:0]   rsp_rdata;
    } iad_regs_t;

    iad_regs_t r;
    iad_regs_t next_r;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic [15:0]           file_select_pointer;
    logic                  req_fire;
    logic                  in_flash;
    logic                  in_trad;
    logic                  in_lin;
    logic                  port_hit;
    logic [11:0]           lin_off;
    logic [11:0]           lin_bank;
    logic [11:0]           lin_idx;
    logic [IAD_RAM_AW-1:0] lin_abs;

    assign file_select_pointer = req_sel ? {pointer_high_byte1, pointer_low_byte1}
                                         : {pointer_high_byte0, pointer_low_byte0};
    // Combinational so that a new request can be taken in the answer cycle
    assign req_ready = (r.st == IAD_IDLE);
    assign req_fire  = req_valid && req_ready;

    assign in_flash = file_select_pointer[IAD_FLASH_BIT];
    assign in_trad  = !in_flash && (file_select_pointer <= IAD_TRAD_LAST);
    assign in_lin   = (file_select_pointer >= IAD_LIN_FIRST)
                   && (file_select_pointer <= IAD_LIN_LAST);
    // The ports sit at the same offset in every bank, so only the low bits matter
    assign port_hit = in_trad && ((file_select_pointer[6:0] == IAD_PORT0_OFS)
                               || (file_select_pointer[6:0] == IAD_PORT1_OFS));

    // Division by a constant; the offset never exceeds 12 bits so this stays small
    assign lin_off  = 12'(file_select_pointer - IAD_LIN_FIRST);
    assign lin_bank = lin_off / IAD_LIN_BLOCK;
    assign lin_idx  = lin_off % IAD_LIN_BLOCK;
    // Bank number fills the bank field; the index stays below 0x70, so no carry reaches it
    assign lin_abs  = {lin_bank[4:0], 7'(IAD_GPR_BASE + lin_idx[6:0])};

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        next_r           = r;
        next_r.ram_re    = 1'b0;
        next_r.ram_we    = 1'b0;
        next_r.flash_re  = 1'b0;
        next_r.rsp_valid = 1'b0;
        case (r.st)
            IAD_IDLE: begin
                if (req_fire) begin
                    next_r.st       = IAD_ISSUE;
                    next_r.is_write = req_write;
                    next_r.to_flash = in_flash;
                    next_r.to_null  = !in_flash && (!(in_trad || in_lin) || port_hit);
                    next_r.ram_wdata = req_wdata;
                    if (in_flash) begin
                        next_r.flash_addr = file_select_pointer[IAD_FLASH_AW-1:0];
                        next_r.flash_re   = !req_write;
                    end else if (in_lin) begin
                        next_r.ram_addr = lin_abs;
                        next_r.ram_re   = !req_write;
                        next_r.ram_we   = req_write;
                    end else if (in_trad && !port_hit) begin
                        next_r.ram_addr = file_select_pointer[IAD_RAM_AW-1:0];
                        next_r.ram_re   = !req_write;
                        next_r.ram_we   = req_write;
                    end
                end
            end
            // Flash writes pay the extra cycle too, so latency depends on the region alone
            IAD_ISSUE: begin
                next_r.st = r.to_flash ? IAD_FLEXTRA : IAD_CAPTURE;
            end
            IAD_FLEXTRA: begin
                next_r.st = IAD_CAPTURE;
            end
            IAD_CAPTURE: begin
                next_r.st        = IAD_IDLE;
                next_r.rsp_valid = 1'b1;
                // Writes answer zero as well, so the core never latches a stale byte
                if (r.is_write || r.to_null) begin
                    next_r.rsp_rdata = IAD_ZERO_BYTE;
                end else if (r.to_flash) begin
                    next_r.rsp_rdata = flash_rdata[IAD_DATA_W-1:0];
                end else begin
                    next_r.rsp_rdata = ram_rdata;
                end
            end
            default: begin
                next_r.st = IAD_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign rsp_valid  = r.rsp_valid;
    assign rsp_rdata  = r.rsp_rdata;
    assign ram_addr   = r.ram_addr;
    assign ram_re     = r.ram_re;
    assign ram_we     = r.ram_we;
    assign ram_wdata  = r.ram_wdata;
    assign flash_addr = r.flash_addr;
    assign flash_re   = r.flash_re;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_data_take;
        req_fire && !in_flash && (in_lin || (in_trad && !port_hit));
    endsequence

    sequence s_trad_take;
        req_fire && in_trad && !port_hit;
    endsequence

    sequence s_lin_take;
        req_fire && in_lin;
    endsequence

    sequence s_ram_write;
        req_fire && req_write && !in_flash && (in_lin || (in_trad && !port_hit));
    endsequence

    sequence s_flash_write;
        req_fire && in_flash && req_write;
    endsequence

    sequence s_flash_take;
        req_fire && in_flash;
    endsequence

    sequence s_null_take;
        req_fire && !in_flash && (!(in_trad || in_lin) || port_hit);
    endsequence

    property p_data_latency;
        s_data_take |-> ##2 !rsp_valid ##1 rsp_valid;
    endproperty
    a_data_latency: assert property (p_data_latency) else $error("data answer not in 3 cycles");

    property p_flash_latency;
        s_flash_take |-> ##1 !rsp_valid [*3] ##1 rsp_valid;
    endproperty
    a_flash_latency: assert property (p_flash_latency) else $error("flash answer not in 4 cycles");

    property p_null_zero;
        s_null_take |-> ##3 (rsp_valid && rsp_rdata == IAD_ZERO_BYTE);
    endproperty
    a_null_zero: assert property (p_null_zero) else $error("null access did not read zero");

    property p_null_quiet;
        s_null_take |-> ##1 (!ram_re && !ram_we && !flash_re);
    endproperty
    a_null_quiet: assert property (p_null_quiet) else $error("null access strobed memory");

    property p_flash_no_write;
        s_flash_take |-> ##1 (!ram_we && !ram_re && flash_re == !$past(req_write));
    endproperty
    a_flash_no_write: assert property (p_flash_no_write) else $error("flash write leaked");

    property p_trad_addr;
        s_trad_take |-> ##1 (ram_addr == $past(file_select_pointer[11:0])
                                           && (ram_re || ram_we));
    endproperty
    a_trad_addr: assert property (p_trad_addr) else $error("traditional address wrong");

    property p_lin_in_gpr;
        s_lin_take |-> ##1 (ram_addr[6:0] >= IAD_GPR_BASE && ram_addr[6:0] < IAD_GPR_END);
    endproperty
    a_lin_in_gpr: assert property (p_lin_in_gpr) else $error("linear hit outside RAM block");

    property p_lin_first;
        (req_fire && in_lin && lin_off == IAD_LIN_BLOCK) |-> ##1 (ram_addr == {5'h01, IAD_GPR_BASE});
    endproperty
    a_lin_first: assert property (p_lin_first) else $error("bank step not contiguous");

    property p_flash_low_byte;
        (r.st == IAD_CAPTURE && r.to_flash && !r.is_write)
            |-> ##1 (rsp_rdata == $past(flash_rdata[7:0]));
    endproperty
    a_flash_low_byte: assert property (p_flash_low_byte) else $error("flash byte wrong");

    property p_flash_addr;
        s_flash_take |-> ##1 (flash_addr == $past(file_select_pointer[14:0]));
    endproperty
    a_flash_addr: assert property (p_flash_addr) else $error("flash address wrong");

    // Inverse of the linear map: bank times block size plus byte index gives the offset back
    property p_lin_inverse;
        s_lin_take |-> ##1 (((ram_addr[11:7] * IAD_LIN_BLOCK) + (ram_addr[6:0] - IAD_GPR_BASE))
                            == $past(lin_off));
    endproperty
    a_lin_inverse: assert property (p_lin_inverse) else $error("linear offset not recovered");

    property p_ram_write;
        s_ram_write |-> ##1 (ram_we && !ram_re && ram_wdata == $past(req_wdata));
    endproperty
    a_ram_write: assert property (p_ram_write) else $error("write byte not passed to RAM");

    property p_flash_write_zero;
        s_flash_write |-> ##4 (rsp_valid && rsp_rdata == IAD_ZERO_BYTE);
    endproperty
    a_flash_write_zero: assert property (p_flash_write_zero) else $error("flash write answer wrong");

    property p_busy;
        req_fire |-> ##1 !req_ready ##1 !req_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("ready while an access is in flight");

    property p_rsp_pulse;
        rsp_valid |-> ##1 !rsp_valid;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer strobe longer than one cycle");

    // Strobes come only from a fresh take, never from state left by an earlier access
    property p_strobe_source;
        (ram_re || ram_we || flash_re) |-> $past(req_fire);
    endproperty
    a_strobe_source: assert property (p_strobe_source) else $error("memory strobe without a take");

    property p_rdata_hold;
        !rsp_valid |-> ##1 (rsp_valid || $stable(rsp_rdata));
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read byte changed between answers");

    property p_ready_on_answer;
        rsp_valid |-> req_ready;
    endproperty
    a_ready_on_answer: assert property (p_ready_on_answer) else $error("not ready in answer cycle");

endmodule

`default_nettype wire

/* File: logic/iad_pkg.sv */
// Shared constants and types for the indirect address decoder
`default_nettype none

package iad_pkg;

    // ****************************************************************
    // Pointer regions
    // ****************************************************************
    localparam logic [15:0] IAD_TRAD_LAST   = 16'h0FFF;
    localparam logic [15:0] IAD_LIN_FIRST   = 16'h2000;
    localparam logic [15:0] IAD_LIN_LAST    = 16'h29AF;
    localparam int          IAD_FLASH_BIT   = 15;

    // ****************************************************************
    // Banked data memory layout
    // ****************************************************************
    localparam logic [11:0] IAD_LIN_BLOCK   = 12'h050;
    localparam logic [6:0]  IAD_GPR_BASE    = 7'h20;
    localparam logic [6:0]  IAD_PORT0_OFS   = 7'h00;
    localparam logic [6:0]  IAD_PORT1_OFS   = 7'h01;
    localparam logic [6:0]  IAD_GPR_END     = 7'h70;

    // ****************************************************************
    // Widths and answer values
    // ****************************************************************
    localparam int          IAD_DATA_W      = 8;
    localparam int          IAD_RAM_AW      = 12;
    localparam int          IAD_FLASH_AW    = 15;
    localparam int          IAD_FLASH_DW    = 14;
    localparam logic [7:0]  IAD_ZERO_BYTE   = 8'h00;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        IAD_IDLE    = 2'b00,
        IAD_ISSUE   = 2'b01,
        IAD_FLEXTRA = 2'b10,
        IAD_CAPTURE = 2'b11
    } iad_state_t;

endpackage

`default_nettype wire

/* File: verif/iad_mem_model.sv */
// Data RAM and program flash model on the far side of the decoder
`timescale 1ns/1ps
`default_nettype none

module iad_mem_model
    import iad_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic [IAD_RAM_AW-1:0]   ram_addr,
    input  wire logic                    ram_re,
    input  wire logic                    ram_we,
    input  wire logic [IAD_DATA_W-1:0]   ram_wdata,
    output var logic  [IAD_DATA_W-1:0]   ram_rdata,
    input  wire logic [IAD_FLASH_AW-1:0] flash_addr,
    input  wire logic                    flash_re,
    output var logic  [IAD_FLASH_DW-1:0] flash_rdata
);
    logic [7:0]  mem [4096];
    logic        fl_pend;
    logic [14:0] fl_a;

    initial begin
        for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 7);
    end

    // Outside its one valid cycle the data flips, so a sample taken late fails
    always @(posedge core_clk) begin
        if (ram_we) mem[ram_addr] <= ram_wdata;
        ram_rdata <= ram_re ? mem[ram_addr] : ~ram_rdata;
        fl_pend <= flash_re;
        fl_a <= flash_addr;
        flash_rdata <= fl_pend ? {fl_a[13:8] ^ 6'h2A, fl_a[7:0] ^ 8'h5A} : ~flash_rdata;
    end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the indirect address decoder
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import iad_pkg::*;
    logic        core_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_sel = 1'b0;
    logic [7:0]  req_wdata = 8'h00, ph0 = 8'h00, pl0 = 8'h00, ph1 = 8'h00, pl1 = 8'h00;
    logic        req_ready, rsp_valid, ram_re, ram_we, flash_re;
    logic [7:0]  rsp_rdata, ram_wdata, ram_rdata;
    logic [11:0] ram_addr;
    logic [14:0] flash_addr;
    logic [13:0] flash_rdata;
    logic [7:0]  shadow [4096];
    logic [15:0] p;
    logic [1:0]  r;
    int          fails = 0, samples_checked = 0, cycles = 0;
    integer      seed = 32'he4681b6e;

    iad_decoder dut (.core_clk, .rst, .req_valid, .req_ready, .req_write, .req_sel, .req_wdata,
        .pointer_high_byte0(ph0), .pointer_low_byte0(pl0), .pointer_high_byte1(ph1),
        .pointer_low_byte1(pl1), .rsp_valid, .rsp_rdata, .ram_addr, .ram_re, .ram_we,
        .ram_wdata, .ram_rdata, .flash_addr, .flash_re, .flash_rdata);
    iad_mem_model mem (.core_clk, .ram_addr, .ram_re, .ram_we, .ram_wdata, .ram_rdata,
        .flash_addr, .flash_re, .flash_rdata);

    always #20 core_clk = ~core_clk;
    // About 120 accesses of at most four cycles each; the ceiling leaves ample slack
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic chk_bit(string name, logic exp, logic got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s exp %b got %b", name, exp, got);
        end
    endtask

    task automatic chk_val(string name, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask

    // ****************************************************************
    // One access against the reference map; kind 0 null, 1 RAM, 2 flash
    // ****************************************************************
    task automatic access(logic wr, logic [15:0] ptr);
        logic [1:0]  kind;
        logic [11:0] a;
        logic [7:0]  wd, exp_rd;
        int          off, lat;
        wd = 8'($random(seed));
        off = int'(ptr) - 'h2000;
        a = ptr[11:0];
        kind = 2'd1;
        if (ptr[15]) kind = 2'd2;
        else if (ptr <= 16'h0FFF) begin
            if (ptr[6:0] < 7'h02) kind = 2'd0;
        end else if (off >= 0 && ptr <= 16'h29AF) a = 12'((off / 80) * 128 + 32 + off % 80);
        else kind = 2'd0;
        lat = (kind == 2'd2) ? 4 : 3;
        exp_rd = 8'h00;
        if (!wr && kind == 2'd1) exp_rd = shadow[a];
        if (!wr && kind == 2'd2) exp_rd = ptr[7:0] ^ 8'h5A;
        if (wr && kind == 2'd1) shadow[a] = wd;
        req_sel = 1'($random(seed));
        {ph0, pl0, ph1, pl1} = $random(seed);
        if (req_sel) {ph1, pl1} = ptr;
        else {ph0, pl0} = ptr;
        req_write = wr;
        req_wdata = wd;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        for (int n = 1; n <= lat; n++) begin
            @(negedge core_clk);
            if (n == 1) begin
                // Pointers change after the take; the decoder must have captured them
                req_valid = 1'b0;
                {ph0, pl0, ph1, pl1} = $random(seed);
                req_write = 1'($random(seed));
            end
            chk_bit("ram_re", n == 1 && kind == 2'd1 && !wr, ram_re);
            chk_bit("ram_we", n == 1 && kind == 2'd1 && wr, ram_we);
            chk_bit("flash_re", n == 1 && kind == 2'd2 && !wr, flash_re);
            chk_bit("rsp_valid", n == lat, rsp_valid);
            chk_bit("req_ready", n == lat, req_ready);
            if (n == 1 && kind == 2'd1) chk_val("ram_addr", 16'(a), 16'(ram_addr));
            if (n == 1 && kind == 2'd1 && wr) chk_val("ram_wdata", 16'(wd), 16'(ram_wdata));
            if (n == 1 && kind == 2'd2 && !wr) chk_val("flash_addr", {1'b0, ptr[14:0]}, 16'(flash_addr));
        end
        chk_val("rsp_rdata", 16'(exp_rd), 16'(rsp_rdata));
    endtask

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    logic [15:0] dir [18] = '{16'h0000, 16'h0001, 16'h0081, 16'h0F81, 16'h0020, 16'h0FFF,
        16'h0070, 16'h2000, 16'h204F, 16'h2050, 16'h29AF, 16'h29B0, 16'h1000, 16'h1FFF,
        16'h7FFF, 16'h8000, 16'hFFFF, 16'hA5C3};

    initial begin
        for (int i = 0; i < 4096; i++) shadow[i] = 8'(i * 7);
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        chk_bit("req_ready", 1'b1, req_ready);
        chk_bit("rsp_valid", 1'b0, rsp_valid);
        chk_val("rsp_rdata", 16'h0000, 16'(rsp_rdata));
        foreach (dir[i]) begin
            access(1'b1, dir[i]);
            access(1'b0, dir[i]);
        end
        access(1'b0, 16'h00A0);
        access(1'b0, 16'h006F);
        repeat (80) begin
            p = 16'($random(seed));
            r = 2'($random(seed));
            if (r == 2'd0) p[15:12] = 4'h0;
            if (r == 2'd1) p = 16'h2000 + p % 16'h09B0;
            access(1'($random(seed)), p);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
